/* File: design/regulator_control.sv */
// Function
// - forced PWM bit clear: automatic choice between PWM and light-load skip mode.
// - forced PWM bit set: PWM always, skip mode never entered.
// - forced PWM ignored until power good has been reached once after turn-on.
// - enable pin low: shutdown with output discharge, regardless of enable bit.
// - enable pin high: enable bit 5 chooses interface-only/Hi-Z or fully active.
// - low supply lockout disables the device.
// - at turn-on the current limit rises gradually to maximum; that is soft start.
// - range bit selects 1.8-4.975 V or 2.025-5.2 V spans, 25 mV resolution.
// - voltage equals 7-bit active code times 25 mV plus range base.
// - select pin low picks first target code, high picks second.
// - regulated level moves toward differing target in 25 mV steps.
// - 2-bit slew field picks one of four ramp rates, 1 to 10 V/ms.
// - slew encoding: 00 1 V/ms, 01 2.5, 10 5, 11 10 V/ms.
// - ramp starts on select pin change or new value in active target.
// - target change before soft start ends is adopted at once, no ramp.
// - ramp PWM bit set: forced PWM for whole ramp duration.
// - ramp PWM function is control register bit 2.
// - switching stops while input above 5.7 V, resumes when below.
// - converter off above 155 C, back on below 135 C.
// - overtemperature detection sets the overtemp flag.
// - status read clears overtemp flag only when below 135 C.
// - power good set above 95 percent, withdrawn below 90 percent.
// - power not good sets the not-good flag; status read clears it while good.
// - shut down means input disconnected from output both ways.
//
// The implementer's own choices: the address map and strobed register access.
module regulator_control
  import regulator_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID    = 8'hA5, // arbitrary value
  parameter int         LIMIT_LEVELS = 8,
  parameter int         SOFT_CYC     = SOFT_STEP_CYC
) (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // register port
  input  wire logic [7:0]        ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR_STB,
  input  wire logic              RD_STB,
  output logic      [7:0]        RDATA,
  // package pins
  input  wire logic              EN_PIN,
  input  wire logic              TARGET_SELECT_PIN,
  // analog indications
  input  wire logic              LOW_SUPPLY_LOCKOUT,
  input  wire logic              INPUT_OVERVOLTAGE_STOP,
  input  wire logic              TEMP_ABOVE_155,
  input  wire logic              TEMP_BELOW_135,
  input  wire logic              OUT_ABOVE_95PCT,
  input  wire logic              OUT_BELOW_90PCT,
  // power stage control
  output logic                   SHUTDOWN,
  output logic                   OUTPUT_DISCHARGE,
  output logic                   OUTPUT_ENABLE,
  output logic                   LOAD_DISCONNECT,
  output logic                   SWITCH_ENABLE,
  output logic                   FORCED_PWM,
  output logic                   LIGHT_LOAD_SKIP_MODE,
  output logic [LIMIT_W-1:0]     CURRENT_LIMIT_LEVEL,
  output logic                   SOFT_START_DONE,
  output logic                   POWER_GOOD,
  output logic                   RAMPING,
  output logic [6:0]             REGULATED_CODE,
  output logic                   RANGE_HIGH,
  output logic [12:0]            REGULATED_MV,
  output logic                   AUDIO_BAND_ENABLE
);

  // refuse settings the counters cannot hold
  if (LIMIT_LEVELS < 2 || LIMIT_LEVELS > (1 << LIMIT_W)) begin : g_chk_levels
    $error("LIMIT_LEVELS out of range");
  end
  if (SOFT_CYC < 1 || SOFT_CYC > 256) begin : g_chk_soft
    $error("SOFT_CYC out of range");
  end

  localparam logic [LIMIT_W-1:0] LIMIT_TOP = LIMIT_W'(LIMIT_LEVELS - 1);
  localparam logic [7:0]         SOFT_TOP  = 8'(SOFT_CYC - 1);

  // cycles per 25 mV step for each slew code
  function automatic logic [9:0] step_cycles(input logic [1:0] slew);
    logic [9:0] c;
    c = 10'(STEP0_CYC);
    case (slew)
      2'h0:    c = 10'(STEP0_CYC);
      2'h1:    c = 10'(STEP1_CYC);
      2'h2:    c = 10'(STEP2_CYC);
      2'h3:    c = 10'(STEP3_CYC);
      default: c = 10'(STEP0_CYC);
    endcase
    return c;
  endfunction : step_cycles

  // millivolts from code and range
  function automatic logic [12:0] code_to_mv(input logic [6:0] code, input logic high);
    int base;
    base = high ? HIGH_BASE_MV : LOW_BASE_MV;
    return 13'(int'(code) * STEP_MV + base);
  endfunction : code_to_mv

  state_s st_r;
  state_s st_nxt;

  pins_s       pins_in;
  logic [7:0]  agree;
  logic        conv_on;
  logic [6:0]  target_code;
  logic        ramp_now;
  logic        forced_now;
  logic        status_rd;
  logic [7:0]  status_val;
  logic [9:0]  step_top;

  // gather pins into one carrier
  assign pins_in = '{en:            EN_PIN,
                     target_sel:    TARGET_SELECT_PIN,
                     supply_low:    LOW_SUPPLY_LOCKOUT,
                     vin_over:      INPUT_OVERVOLTAGE_STOP,
                     temp_above_hi: TEMP_ABOVE_155,
                     temp_below_lo: TEMP_BELOW_135,
                     out_above_hi:  OUT_ABOVE_95PCT,
                     out_below_lo:  OUT_BELOW_90PCT};

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;

    // three-stage synchroniser; a level counts once stages two and three agree
    st_nxt.sync1 = pins_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    agree        = ~(st_r.sync2 ^ st_r.sync3);
    st_nxt.filt  = (st_r.filt & ~agree) | (st_r.sync3 & agree);

    // thermal hysteresis between the two comparators
    if (st_r.filt.temp_above_hi) begin
      st_nxt.hot = 1'b1;
    end else if (st_r.filt.temp_below_lo) begin
      st_nxt.hot = 1'b0;
    end

    // converter runs only with pin, bit, supply and temperature all good
    conv_on = st_r.filt.en & ~st_r.filt.supply_low & st_r.control[ENABLE_BIT] & ~st_r.hot;

    // power good with hysteresis; meaningless while the converter is off
    if (!conv_on) begin
      st_nxt.power_good = 1'b0;
    end else if (st_r.filt.out_above_hi) begin
      st_nxt.power_good = 1'b1;
    end else if (st_r.filt.out_below_lo) begin
      st_nxt.power_good = 1'b0;
    end

    // first power good since turn-on unlocks forced PWM
    if (!conv_on) begin
      st_nxt.pg_seen = 1'b0;
    end else if (st_r.power_good) begin
      st_nxt.pg_seen = 1'b1;
    end

    // soft start: current limit climbs one level per pacing period
    if (!conv_on) begin
      st_nxt.limit_level = '0;
      st_nxt.soft_cnt    = 8'h00;
      st_nxt.soft_done   = 1'b0;
    end else if (!st_r.soft_done) begin
      if (st_r.soft_cnt == SOFT_TOP) begin
        st_nxt.soft_cnt = 8'h00;
        if (st_r.limit_level == LIMIT_TOP) begin
          st_nxt.soft_done = 1'b1;
        end else begin
          st_nxt.limit_level = st_r.limit_level + 1'b1;
        end
      end else begin
        st_nxt.soft_cnt = st_r.soft_cnt + 8'h01;
      end
    end

    // active target follows the select pin
    target_code = st_r.filt.target_sel ? st_r.second_code : st_r.first_code;
    step_top    = step_cycles(st_r.control[SLEW_MSB:SLEW_LSB]) - 10'h001;

    // a ramp is simply a present code that differs from the target, so a
    // pin toggle or a new active code starts one and a change mid-ramp
    // carries on from the present level
    ramp_now = st_r.soft_done & (st_r.present_code != target_code);
    if (!st_r.soft_done) begin
      st_nxt.present_code = target_code;
      st_nxt.step_cnt     = 10'h000;
    end else if (ramp_now) begin
      if (st_r.step_cnt >= step_top) begin
        st_nxt.step_cnt = 10'h000;
        if (target_code > st_r.present_code) begin
          st_nxt.present_code = st_r.present_code + 7'h01;
        end else begin
          st_nxt.present_code = st_r.present_code - 7'h01;
        end
      end else begin
        st_nxt.step_cnt = st_r.step_cnt + 10'h001;
      end
    end else begin
      st_nxt.step_cnt = 10'h000;
    end

    // range changes take effect at once; software should avoid them live
    st_nxt.present_mv = code_to_mv(st_r.present_code, st_r.control[RANGE_BIT]);

    // mode choice: forced bit after first power good, or ramp PWM while ramping
    forced_now = (st_r.control[FORCED_PWM_BIT] & st_r.pg_seen) | (st_r.control[RAMP_PWM_BIT] & ramp_now);

    // power stage outputs
    st_nxt.shutdown        = ~st_r.filt.en | st_r.filt.supply_low;
    st_nxt.discharge       = ~st_r.filt.en;
    st_nxt.out_enable      = conv_on;
    st_nxt.load_disconnect = ~conv_on;
    st_nxt.switch_enable   = conv_on & ~st_r.filt.vin_over;
    st_nxt.forced_pwm      = forced_now;
    st_nxt.ramping         = ramp_now;

    // status value as seen before any clear
    status_val               = 8'h00;
    status_val[OVERTEMP_BIT] = st_r.overtemp_flag;
    status_val[NOT_GOOD_BIT] = st_r.output_not_good_flag;
    status_rd                = RD_STB & (ADDR == ADDR_STATUS);

    // sticky flags; a set in the cycle of a read wins over the clear
    st_nxt.overtemp_flag = st_r.hot | (st_r.overtemp_flag & ~(status_rd & ~st_r.hot));
    st_nxt.output_not_good_flag = (conv_on & ~st_r.power_good) |
                                  (st_r.output_not_good_flag & ~(status_rd & st_r.power_good));

    // register writes; status and identity are read-only
    if (WR_STB) begin
      case (ADDR)
        ADDR_CONTROL:       st_nxt.control     = WDATA;
        ADDR_FIRST_TARGET:  st_nxt.first_code  = WDATA[6:0];
        ADDR_SECOND_TARGET: st_nxt.second_code = WDATA[6:0];
        default:            st_nxt.control     = st_r.control;
      endcase
    end

    // register reads, answered in the next cycle only; unmapped reads zero
    if (RD_STB) begin
      case (ADDR)
        ADDR_CONTROL:       st_nxt.rdata = st_r.control;
        ADDR_STATUS:        st_nxt.rdata = status_val;
        ADDR_DEVICE_ID:     st_nxt.rdata = DEVICE_ID;
        ADDR_FIRST_TARGET:  st_nxt.rdata = {1'b0, st_r.first_code};
        ADDR_SECOND_TARGET: st_nxt.rdata = {1'b0, st_r.second_code};
        default:            st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // state register; pins reset to the safe shut-down reading
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r                 <= '0;
      st_r.control         <= CONTROL_RESET;
      st_r.first_code      <= FIRST_TARGET_RESET;
      st_r.second_code     <= SECOND_TARGET_RESET;
      st_r.present_code    <= FIRST_TARGET_RESET;
      st_r.shutdown        <= 1'b1;
      st_r.discharge       <= 1'b1;
      st_r.load_disconnect <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign RDATA                = st_r.rdata;
  assign SHUTDOWN             = st_r.shutdown;
  assign OUTPUT_DISCHARGE     = st_r.discharge;
  assign OUTPUT_ENABLE        = st_r.out_enable;
  assign LOAD_DISCONNECT      = st_r.load_disconnect;
  assign SWITCH_ENABLE        = st_r.switch_enable;
  assign FORCED_PWM           = st_r.forced_pwm;
  assign LIGHT_LOAD_SKIP_MODE = ~st_r.forced_pwm;
  assign CURRENT_LIMIT_LEVEL  = st_r.limit_level;
  assign SOFT_START_DONE      = st_r.soft_done;
  assign POWER_GOOD           = st_r.power_good;
  assign RAMPING              = st_r.ramping;
  assign REGULATED_CODE       = st_r.present_code;
  assign RANGE_HIGH           = st_r.control[RANGE_BIT];
  assign REGULATED_MV         = st_r.present_mv;
  assign AUDIO_BAND_ENABLE    = st_r.control[AUDIO_BAND_BIT];

endmodule : regulator_control

/* File: design/regulator_pkg.sv */
package regulator_pkg;

  // register offsets, byte addressed on the 8-bit register port
  localparam logic [7:0] ADDR_CONTROL       = 8'h01;
  localparam logic [7:0] ADDR_STATUS        = 8'h02;
  localparam logic [7:0] ADDR_DEVICE_ID     = 8'h03;
  localparam logic [7:0] ADDR_FIRST_TARGET  = 8'h04;
  localparam logic [7:0] ADDR_SECOND_TARGET = 8'h05;

  // reset values
  localparam logic [7:0] CONTROL_RESET       = 8'h20;
  localparam logic [6:0] FIRST_TARGET_RESET  = 7'h3C;
  localparam logic [6:0] SECOND_TARGET_RESET = 7'h42;

  // control register field positions
  localparam int RANGE_BIT      = 6;
  localparam int ENABLE_BIT     = 5;
  localparam int AUDIO_BAND_BIT = 4;
  localparam int FORCED_PWM_BIT = 3;
  localparam int RAMP_PWM_BIT   = 2;
  localparam int SLEW_MSB       = 1;
  localparam int SLEW_LSB       = 0;

  // status register field positions
  localparam int NOT_GOOD_BIT = 0;
  localparam int OVERTEMP_BIT = 1;

  // voltage scale
  localparam int STEP_MV      = 25;
  localparam int LOW_BASE_MV  = 1800;
  localparam int HIGH_BASE_MV = 2025;

  // clock and ramp pacing
  localparam int CLK_FREQ_MHZ    = 25;
  localparam int RATE0_MV_PER_MS = 1000;
  localparam int RATE1_MV_PER_MS = 2500;
  localparam int RATE2_MV_PER_MS = 5000;
  localparam int RATE3_MV_PER_MS = 10000;
  localparam int STEP0_NS        = STEP_MV * 1000000 / RATE0_MV_PER_MS;
  localparam int STEP1_NS        = STEP_MV * 1000000 / RATE1_MV_PER_MS;
  localparam int STEP2_NS        = STEP_MV * 1000000 / RATE2_MV_PER_MS;
  localparam int STEP3_NS        = STEP_MV * 1000000 / RATE3_MV_PER_MS;
  localparam int STEP0_CYC       = STEP0_NS * CLK_FREQ_MHZ / 1000;
  localparam int STEP1_CYC       = STEP1_NS * CLK_FREQ_MHZ / 1000;
  localparam int STEP2_CYC       = STEP2_NS * CLK_FREQ_MHZ / 1000;
  localparam int STEP3_CYC       = STEP3_NS * CLK_FREQ_MHZ / 1000;

  // soft start pacing of the current limit
  localparam int SOFT_STEP_NS  = 5000;
  localparam int SOFT_STEP_CYC = (SOFT_STEP_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int LIMIT_W       = 3;

  // pins from the analog side and the package pins
  typedef struct packed {
    logic en;
    logic target_sel;
    logic supply_low;
    logic vin_over;
    logic temp_above_hi;
    logic temp_below_lo;
    logic out_above_hi;
    logic out_below_lo;
  } pins_s;

  typedef struct packed {
    logic [7:0]         control;
    logic [6:0]         first_code;
    logic [6:0]         second_code;
    logic               overtemp_flag;
    logic               output_not_good_flag;
    pins_s              sync1;
    pins_s              sync2;
    pins_s              sync3;
    pins_s              filt;
    logic               hot;
    logic               power_good;
    logic               pg_seen;
    logic [LIMIT_W-1:0] limit_level;
    logic [7:0]         soft_cnt;
    logic               soft_done;
    logic [6:0]         present_code;
    logic [9:0]         step_cnt;
    logic [12:0]        present_mv;
    logic [7:0]         rdata;
    logic               shutdown;
    logic               discharge;
    logic               out_enable;
    logic               load_disconnect;
    logic               switch_enable;
    logic               forced_pwm;
    logic               ramping;
  } state_s;

endpackage : regulator_pkg

/* File: test/analog_sense_model.sv */
module analog_sense_model (
  // converter state and environment
  input  wire logic output_enable,
  input  var  int   out_pct,
  input  var  int   temp_c,
  // comparator outputs
  output logic      out_above,
  output logic      out_below,
  output logic      temp_above,
  output logic      temp_below
);
  timeunit 1ns;
  timeprecision 1ns;
  // output collapses when the converter is off, so no stale good level
  assign out_above  = output_enable && out_pct > 95;
  assign out_below  = !output_enable || out_pct < 90;
  assign temp_above = temp_c > 155;
  assign temp_below = temp_c < 135;
endmodule : analog_sense_model

/* File: test/regulator_control_asserts.sv */
module regulator_control_asserts
  import regulator_pkg::*;
#(
  parameter int LIMIT_LEVELS = 8
) (
  // clock and reset
  input wire logic               CLK,
  input wire logic               RESET,
  // power stage control
  input wire logic               SHUTDOWN,
  input wire logic               OUTPUT_DISCHARGE,
  input wire logic               OUTPUT_ENABLE,
  input wire logic               LOAD_DISCONNECT,
  input wire logic               SWITCH_ENABLE,
  input wire logic               FORCED_PWM,
  input wire logic               LIGHT_LOAD_SKIP_MODE,
  input wire logic [LIMIT_W-1:0] CURRENT_LIMIT_LEVEL,
  input wire logic               SOFT_START_DONE,
  input wire logic               POWER_GOOD,
  input wire logic               RAMPING,
  input wire logic [6:0]         REGULATED_CODE,
  input wire logic               RANGE_HIGH,
  input wire logic [12:0]        REGULATED_MV
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // output relations that must hold every cycle
  property p_disc; LOAD_DISCONNECT == !OUTPUT_ENABLE; endproperty
  a_disc: assert property (p_disc) else $error("load disconnect not inverse of enable");
  property p_skip; LIGHT_LOAD_SKIP_MODE == !FORCED_PWM; endproperty
  a_skip: assert property (p_skip) else $error("skip mode and forced pwm overlap");
  property p_dis; OUTPUT_DISCHARGE |-> SHUTDOWN && !OUTPUT_ENABLE; endproperty
  a_dis: assert property (p_dis) else $error("discharge while not shut down");
  property p_sw; SWITCH_ENABLE |-> OUTPUT_ENABLE; endproperty
  a_sw: assert property (p_sw) else $error("switching while converter off");
  // ramp moves one code at a time once soft start is over
  property p_step;
    $changed(REGULATED_CODE) && SOFT_START_DONE && $past(SOFT_START_DONE)
      |-> REGULATED_CODE == $past(REGULATED_CODE) + 7'h01 || REGULATED_CODE == $past(REGULATED_CODE) - 7'h01;
  endproperty
  a_step: assert property (p_step) else $error("ramp step larger than one code");
  // first edge after reset skipped: millivolt value is one cycle behind
  property p_mv;
    !$past(RESET) && $stable(REGULATED_CODE) && $stable(RANGE_HIGH)
      |-> REGULATED_MV == 13'(REGULATED_CODE) * 13'h19 + (RANGE_HIGH ? 13'h7E9 : 13'h708);
  endproperty
  a_mv: assert property (p_mv) else $error("millivolt value does not match code");
  property p_lim;
    $changed(CURRENT_LIMIT_LEVEL) |-> CURRENT_LIMIT_LEVEL == $past(CURRENT_LIMIT_LEVEL) + 3'h1 || CURRENT_LIMIT_LEVEL == 3'h0;
  endproperty
  a_lim: assert property (p_lim) else $error("current limit jumped");
  property p_done; SOFT_START_DONE |-> CURRENT_LIMIT_LEVEL == LIMIT_W'(LIMIT_LEVELS - 1); endproperty
  a_done: assert property (p_done) else $error("soft start done below full limit");
  property p_noramp; !SOFT_START_DONE && !$past(SOFT_START_DONE) |-> !RAMPING; endproperty
  a_noramp: assert property (p_noramp) else $error("ramping during soft start");
  property p_pgoff; !OUTPUT_ENABLE [*3] |-> !POWER_GOOD; endproperty
  a_pgoff: assert property (p_pgoff) else $error("power good while converter off");

  // main scenarios
  c_ramp_pwm: cover property (RAMPING && FORCED_PWM);
  c_soft: cover property ($rose(SOFT_START_DONE));
  c_idle: cover property (!OUTPUT_ENABLE && !SHUTDOWN);
endmodule : regulator_control_asserts

bind regulator_control regulator_control_asserts #(.LIMIT_LEVELS(LIMIT_LEVELS)) regulator_control_asserts_inst (
  .CLK(CLK), .RESET(RESET), .SHUTDOWN(SHUTDOWN), .OUTPUT_DISCHARGE(OUTPUT_DISCHARGE),
  .OUTPUT_ENABLE(OUTPUT_ENABLE), .LOAD_DISCONNECT(LOAD_DISCONNECT), .SWITCH_ENABLE(SWITCH_ENABLE),
  .FORCED_PWM(FORCED_PWM), .LIGHT_LOAD_SKIP_MODE(LIGHT_LOAD_SKIP_MODE), .CURRENT_LIMIT_LEVEL(CURRENT_LIMIT_LEVEL),
  .SOFT_START_DONE(SOFT_START_DONE), .POWER_GOOD(POWER_GOOD), .RAMPING(RAMPING),
  .REGULATED_CODE(REGULATED_CODE), .RANGE_HIGH(RANGE_HIGH), .REGULATED_MV(REGULATED_MV));

/* File: test/test_buck_boost_mode_and_dvs_control.sv */
module test_buck_boost_mode_and_dvs_control
  import regulator_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] DEV_ID = 8'h5A; // arbitrary value
  logic CLK, RESET, WR_STB, RD_STB, EN_PIN, TARGET_SELECT_PIN, LOW_SUPPLY_LOCKOUT, INPUT_OVERVOLTAGE_STOP;
  logic t_hi, t_lo, o_hi, o_lo, SHUTDOWN, OUTPUT_DISCHARGE, OUTPUT_ENABLE, LOAD_DISCONNECT, SWITCH_ENABLE;
  logic FORCED_PWM, LIGHT_LOAD_SKIP_MODE, SOFT_START_DONE, POWER_GOOD, RAMPING, RANGE_HIGH, AUDIO_BAND_ENABLE;
  logic [7:0]  ADDR, WDATA, RDATA;
  logic [2:0]  CURRENT_LIMIT_LEVEL;
  logic [6:0]  REGULATED_CODE;
  logic [12:0] REGULATED_MV;
  int          out_pct, temp_c, failures, n_checks;

  // small soft start step keeps the start-up short
  regulator_control #(.DEVICE_ID(DEV_ID), .LIMIT_LEVELS(8), .SOFT_CYC(4)) regulator_control_inst (
    .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
    .EN_PIN(EN_PIN), .TARGET_SELECT_PIN(TARGET_SELECT_PIN), .LOW_SUPPLY_LOCKOUT(LOW_SUPPLY_LOCKOUT),
    .INPUT_OVERVOLTAGE_STOP(INPUT_OVERVOLTAGE_STOP), .TEMP_ABOVE_155(t_hi), .TEMP_BELOW_135(t_lo),
    .OUT_ABOVE_95PCT(o_hi), .OUT_BELOW_90PCT(o_lo), .SHUTDOWN(SHUTDOWN), .OUTPUT_DISCHARGE(OUTPUT_DISCHARGE),
    .OUTPUT_ENABLE(OUTPUT_ENABLE), .LOAD_DISCONNECT(LOAD_DISCONNECT), .SWITCH_ENABLE(SWITCH_ENABLE),
    .FORCED_PWM(FORCED_PWM), .LIGHT_LOAD_SKIP_MODE(LIGHT_LOAD_SKIP_MODE), .CURRENT_LIMIT_LEVEL(CURRENT_LIMIT_LEVEL),
    .SOFT_START_DONE(SOFT_START_DONE), .POWER_GOOD(POWER_GOOD), .RAMPING(RAMPING), .REGULATED_CODE(REGULATED_CODE),
    .RANGE_HIGH(RANGE_HIGH), .REGULATED_MV(REGULATED_MV), .AUDIO_BAND_ENABLE(AUDIO_BAND_ENABLE));
  analog_sense_model analog_sense_model_inst (.output_enable(OUTPUT_ENABLE), .out_pct(out_pct), .temp_c(temp_c),
    .out_above(o_hi), .out_below(o_lo), .temp_above(t_hi), .temp_below(t_lo));

  task cmp1(string w, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %b seen %b", w, e, g);
    end
  endtask : cmp1
  task cmpv(string w, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask : cmpv
  // sample a little after the edge so registered outputs have landed
  task tick(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge CLK);
    ADDR <= a; WDATA <= d; WR_STB <= 1'b1;
    @(posedge CLK);
    WR_STB <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe edge
  task rdc(logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
    @(posedge CLK);
    ADDR <= a; RD_STB <= 1'b1;
    @(posedge CLK);
    RD_STB <= 1'b0;
    #1 cmpv("rdata", {8'h00, e & m}, {8'h00, RDATA & m});
  endtask : rdc
  task wait_code(output int n);
    logic [6:0] c;
    c = REGULATED_CODE;
    n = 0;
    while (REGULATED_CODE === c && n < 1000) begin
      tick(1);
      n++;
    end
  endtask : wait_code

  task t_regs;
    rdc(ADDR_CONTROL, CONTROL_RESET); rdc(ADDR_STATUS, 8'h00); rdc(ADDR_DEVICE_ID, DEV_ID);
    rdc(ADDR_FIRST_TARGET, {1'b0, FIRST_TARGET_RESET}); rdc(ADDR_SECOND_TARGET, {1'b0, SECOND_TARGET_RESET});
    rdc(8'h06, 8'h00);
    wr(ADDR_STATUS, 8'hFF); rdc(ADDR_STATUS, 8'h00);
    wr(ADDR_SECOND_TARGET, 8'hC2); rdc(ADDR_SECOND_TARGET, 8'h42);
    cmp1("shutdown", 1'b1, SHUTDOWN);
    cmp1("discharge", 1'b1, OUTPUT_DISCHARGE);
    cmp1("disconnect", 1'b1, LOAD_DISCONNECT);
    $display("test regs done");
  endtask : t_regs
  task t_soft;
    @(posedge CLK) EN_PIN <= 1'b1;
    tick(12); cmp1("limit rising", 1'b1, CURRENT_LIMIT_LEVEL != 3'h0);
    wr(ADDR_CONTROL, 8'h28);
    wr(ADDR_FIRST_TARGET, 8'h40);
    tick(3); cmpv("code", 16'h0040, 16'(REGULATED_CODE));
    cmp1("ramping", 1'b0, RAMPING);
    tick(40); cmp1("soft done", 1'b1, SOFT_START_DONE);
    cmpv("limit", 16'h0007, 16'(CURRENT_LIMIT_LEVEL));
    cmp1("forced before good", 1'b0, FORCED_PWM);
    out_pct = 100;
    tick(10); cmp1("pg", 1'b1, POWER_GOOD);
    cmp1("forced", 1'b1, FORCED_PWM);
    cmp1("skip", 1'b0, LIGHT_LOAD_SKIP_MODE);
    rdc(ADDR_STATUS, 8'h01); rdc(ADDR_STATUS, 8'h00);
    out_pct = 92;
    tick(10); cmp1("pg hyst", 1'b1, POWER_GOOD);
    out_pct = 85;
    tick(10); cmp1("pg lost", 1'b0, POWER_GOOD);
    rdc(ADDR_STATUS, 8'h01); rdc(ADDR_STATUS, 8'h01);
    out_pct = 100;
    wr(ADDR_CONTROL, 8'h20);
    tick(10); cmp1("auto forced", 1'b0, FORCED_PWM);
    cmp1("auto skip", 1'b1, LIGHT_LOAD_SKIP_MODE);
    $display("test soft start done");
  endtask : t_soft
  task t_ramp;
    int per[4];
    int n;
    logic [6:0] c;
    per = '{STEP0_CYC, STEP1_CYC, STEP2_CYC, STEP3_CYC};
    c = 7'h40;
    // odd rates ramp down, even rates ramp up
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CONTROL, 8'h20 | 8'(s));
      c = s[0] ? c - 7'h02 : c + 7'h02;
      wr(ADDR_FIRST_TARGET, {1'b0, c});
      wait_code(n);
      wait_code(n);
      cmpv("step period", 16'(per[s]), 16'(n));
      cmpv("ramp end", 16'(c), 16'(REGULATED_CODE));
      tick(3); cmp1("ramp over", 1'b0, RAMPING);
    end
    wr(ADDR_CONTROL, 8'h27);
    @(posedge CLK) TARGET_SELECT_PIN <= 1'b1;
    wait_code(n); cmp1("pin ramp", 1'b1, RAMPING);
    cmp1("ramp forced", 1'b1, FORCED_PWM);
    wait_code(n); cmpv("second code", 16'h0042, 16'(REGULATED_CODE));
    tick(3); cmp1("forced after", 1'b0, FORCED_PWM);
    cmpv("mv", 16'(7'h42 * STEP_MV + LOW_BASE_MV), 16'(REGULATED_MV));
    wr(ADDR_CONTROL, 8'h23);
    @(posedge CLK) TARGET_SELECT_PIN <= 1'b0;
    wait_code(n); cmp1("ramp not forced", 1'b0, FORCED_PWM);
    wait_code(n); cmpv("first code", 16'h0040, 16'(REGULATED_CODE));
    $display("test ramp done");
  endtask : t_ramp
  task t_protect;
    @(posedge CLK) INPUT_OVERVOLTAGE_STOP <= 1'b1;
    tick(10); cmp1("switch ov", 1'b0, SWITCH_ENABLE);
    cmp1("on during ov", 1'b1, OUTPUT_ENABLE);
    @(posedge CLK) INPUT_OVERVOLTAGE_STOP <= 1'b0;
    tick(10); cmp1("switch back", 1'b1, SWITCH_ENABLE);
    temp_c = 160;
    tick(10); cmp1("hot off", 1'b0, OUTPUT_ENABLE);
    rdc(ADDR_STATUS, 8'h02, 8'h02); rdc(ADDR_STATUS, 8'h02, 8'h02);
    temp_c = 145;
    tick(10); cmp1("warm off", 1'b0, OUTPUT_ENABLE);
    rdc(ADDR_STATUS, 8'h02, 8'h02);
    temp_c = 25;
    tick(10); cmp1("cool on", 1'b1, OUTPUT_ENABLE);
    rdc(ADDR_STATUS, 8'h02, 8'h02); rdc(ADDR_STATUS, 8'h00, 8'h02);
    $display("test protect done");
  endtask : t_protect
  task t_enable;
    tick(50);
    wr(ADDR_CONTROL, 8'h00);
    tick(3); cmp1("bit off", 1'b0, OUTPUT_ENABLE);
    cmp1("bit off shut", 1'b0, SHUTDOWN);
    cmp1("hi-z", 1'b1, LOAD_DISCONNECT);
    wr(ADDR_CONTROL, 8'h50); // range changed only with converter off
    tick(3); cmp1("range", 1'b1, RANGE_HIGH);
    cmp1("audio", 1'b1, AUDIO_BAND_ENABLE);
    cmpv("mv high", 16'(7'h40 * STEP_MV + HIGH_BASE_MV), 16'(REGULATED_MV));
    wr(ADDR_CONTROL, 8'h20);
    tick(3); cmp1("bit on", 1'b1, OUTPUT_ENABLE);
    @(posedge CLK) LOW_SUPPLY_LOCKOUT <= 1'b1;
    tick(10); cmp1("lockout", 1'b1, SHUTDOWN);
    cmp1("lockout off", 1'b0, OUTPUT_ENABLE);
    @(posedge CLK) LOW_SUPPLY_LOCKOUT <= 1'b0;
    tick(10); cmp1("unlock", 1'b1, OUTPUT_ENABLE);
    @(posedge CLK) EN_PIN <= 1'b0;
    tick(10); cmp1("pin off", 1'b1, OUTPUT_DISCHARGE);
    cmp1("pin off on", 1'b0, OUTPUT_ENABLE);
    cmp1("pin disc", 1'b1, LOAD_DISCONNECT);
    $display("test enable done");
  endtask : t_enable
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // 25 MHz clock
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // main sequence
  initial begin
    {RESET, WR_STB, RD_STB, EN_PIN, TARGET_SELECT_PIN, LOW_SUPPLY_LOCKOUT, INPUT_OVERVOLTAGE_STOP} = 7'h40;
    ADDR = 8'h00; WDATA = 8'h00; out_pct = 0; temp_c = 25; failures = 0; n_checks = 0;
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    t_regs; t_soft; t_ramp; t_protect; t_enable;
    conclude;
  end
  // whole run needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge CLK);
    failures++;
    $display("BAD watchdog expected end seen timeout");
    conclude;
  end
endmodule : test_buck_boost_mode_and_dvs_control
